// file: ct_switch_pkg.sv
package ct_switch_pkg;

  // Register index (printed offset), byte address is four times the index
  localparam logic [7:0]  AUG_LEAD_IDX       = 8'h18;
  // Second register shares the printed index; placed at the next word
  localparam logic [7:0]  AMP_BC_IDX         = 8'h19;
  localparam logic [11:0] AUG_LEAD_ADDR      = {2'h0, AUG_LEAD_IDX, 2'h0};
  localparam logic [11:0] AMP_BC_ADDR        = {2'h0, AMP_BC_IDX, 2'h0};
  localparam int          ADDR_W             = 12;

  // Reset values
  localparam logic [7:0]  AUG_LEAD_RST       = 8'h00;
  localparam logic [7:0]  AMP_BC_RST         = 8'h00;

  // Field positions in the augmented lead register
  localparam int          FOOT_CH6_BIT       = 7;
  localparam int          LEFT_CH5_BIT       = 6;
  localparam int          RIGHT_CH7_BIT      = 5;
  localparam int          RIGHT_CH4_BIT      = 4;
  localparam int          AMP_A_PWR_BIT      = 3;
  localparam int          AMP_A_SEL_LSB      = 0;

  // Field positions in the amplifier B/C register
  localparam int          AMP_C_PWR_BIT      = 7;
  localparam int          AMP_B_PWR_BIT      = 6;
  localparam int          AMP_B_SEL_LSB      = 3;
  localparam int          AMP_C_SEL_LSB      = 0;

  localparam int          SEL_W              = 3;
  localparam int          NUM_INPUTS         = 8;

  // One-hot input select lines, bit n = code n
  typedef logic [NUM_INPUTS-1:0] input_onehot_t;

endpackage

// file: ct_input_decoder.sv
`timescale 1ns/1ps
module ct_input_decoder
  import ct_switch_pkg::*;
(
  input  wire logic                 core_clk,  // Core clock
  input  wire logic                 rst_sync_b, // Synchronised reset, active low
  input  wire logic [SEL_W-1:0]     sel,       // Electrode select code
  output logic      [NUM_INPUTS-1:0] onehot    // Registered one-hot switch lines
);
  import ct_switch_pkg::*;

  logic [NUM_INPUTS-1:0] nxt_onehot;
  logic [NUM_INPUTS-1:0] onehot_ff;

  // Code to one-hot: even codes positive, odd codes negative input
  always_comb
  begin
    nxt_onehot = '0;
    nxt_onehot[sel] = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      onehot_ff <= input_onehot_t'(1);
    else
      onehot_ff <= nxt_onehot;
  end

  assign onehot = onehot_ff;

  chk_onehot_line: assert property (@(posedge core_clk) disable iff (!rst_sync_b)
    $onehot(onehot_ff)) else $error("select lines not one-hot");

endmodule

// file: ct_switch_cfg.sv
`timescale 1ns/1ps
// Overview of operation
// - Register 0x18 resets zero, fully read/write
// - Bit 7 routes A+B average to ch6
// - Bit 6 routes A+C average to ch5
// - Bit 5 routes B+C average to ch7
// - Bit 4 routes B+C average to ch4
// - Bit 3 powers central amplifier A
// - Bits 2:0 pick amplifier A input
// - Second register resets zero, read/write
// - Second register bit 7 powers amplifier C
// - Second register bit 6 powers amplifier B
// - Bits 5:3 pick amplifier B input
// - Bits 2:0 pick amplifier C input
module ct_switch_cfg
  import ct_switch_pkg::*;
(
  input  wire logic                  core_clk,                // 40 MHz core clock
  input  wire logic                  rst_b,                   // Async reset, active low
  input  wire logic                  psel,                    // APB select
  input  wire logic                  penable,                 // APB enable
  input  wire logic                  pwrite,                  // APB direction
  input  wire logic [ADDR_W-1:0]     paddr,                   // APB byte address
  input  wire logic [31:0]           pwdata,                  // APB write data
  output logic      [31:0]           prdata,                  // APB read data
  output logic                       pready,                  // APB ready
  output logic                       pslverr,                 // APB error
  output logic                       foot_lead_to_ch6_en,     // A+B average to ch6 neg
  output logic                       left_lead_to_ch5_en,     // A+C average to ch5 neg
  output logic                       right_lead_to_ch7_en,    // B+C average to ch7 neg
  output logic                       right_lead_to_ch4_en,    // B+C average to ch4 neg
  output logic                       central_amp_a_power_on,  // Amplifier A power
  output logic                       central_amp_b_power_on,  // Amplifier B power
  output logic                       central_amp_c_power_on,  // Amplifier C power
  output logic      [NUM_INPUTS-1:0] central_amp_a_input_sel, // A input switch lines
  output logic      [NUM_INPUTS-1:0] central_amp_b_input_sel, // B input switch lines
  output logic      [NUM_INPUTS-1:0] central_amp_c_input_sel  // C input switch lines
);
  import ct_switch_pkg::*;

  logic       rst_meta_ff;
  logic       rst_sync_ff;
  logic [7:0] aug_lead_ff;
  logic [7:0] nxt_aug_lead;
  logic [7:0] amp_bc_ff;
  logic [7:0] nxt_amp_bc;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic       pslverr_ff;
  logic       nxt_pslverr;
  logic       pready_ff;
  logic       nxt_pready;
  logic       access;
  logic       complete;

  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Register map: one byte register per 32-bit word
  // Both registers share one printed index, so the second sits one word up
  // Any other word answers with an error and stores nothing
  // Upper write bits are dropped, upper read bits are zero

  // Address decode shared by read and write paths
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == AUG_LEAD_ADDR) || (a == AMP_BC_ADDR);
  endfunction

  // Access phase; answered in one wait cycle via registered pready
  assign access = psel && penable && !pready_ff;
  // Completion edge: the master samples pready high here, so writes land now
  assign complete = psel && penable && pready_ff;

  // Next register values and APB answer
  always_comb
  begin
    nxt_aug_lead = aug_lead_ff;
    nxt_amp_bc   = amp_bc_ff;
    nxt_prdata   = prdata_ff;
    nxt_pslverr  = 1'b0;
    nxt_pready   = access;
    // Write lands only on the edge where the master sees pready high
    if (complete && pwrite)
    begin
      if (paddr == AUG_LEAD_ADDR)
        nxt_aug_lead = pwdata[7:0];
      if (paddr == AMP_BC_ADDR)
        nxt_amp_bc = pwdata[7:0];
    end
    // First access cycle prepares the answer shown with pready
    if (access)
    begin
      nxt_pslverr = !addr_hit(paddr);
      if (pwrite)
        nxt_prdata = prdata_ff;
      else if (paddr == AUG_LEAD_ADDR)
        nxt_prdata = {24'h000000, aug_lead_ff};
      else if (paddr == AMP_BC_ADDR)
        nxt_prdata = {24'h000000, amp_bc_ff};
      else
        nxt_prdata = 32'h00000000;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      aug_lead_ff <= AUG_LEAD_RST;
      amp_bc_ff   <= AMP_BC_RST;
      prdata_ff   <= 32'h00000000;
      pslverr_ff  <= 1'b0;
      pready_ff   <= 1'b0;
    end
    else
    begin
      aug_lead_ff <= nxt_aug_lead;
      amp_bc_ff   <= nxt_amp_bc;
      prdata_ff   <= nxt_prdata;
      pslverr_ff  <= nxt_pslverr;
      pready_ff   <= nxt_pready;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // Switch and power lines straight from stored bits
  assign foot_lead_to_ch6_en    = aug_lead_ff[FOOT_CH6_BIT];
  assign left_lead_to_ch5_en    = aug_lead_ff[LEFT_CH5_BIT];
  assign right_lead_to_ch7_en   = aug_lead_ff[RIGHT_CH7_BIT];
  assign right_lead_to_ch4_en   = aug_lead_ff[RIGHT_CH4_BIT];
  assign central_amp_a_power_on = aug_lead_ff[AMP_A_PWR_BIT];
  assign central_amp_c_power_on = amp_bc_ff[AMP_C_PWR_BIT];
  assign central_amp_b_power_on = amp_bc_ff[AMP_B_PWR_BIT];

  // Input selection decoders, one per amplifier
  ct_input_decoder u_dec_a (
    .core_clk   (core_clk),
    .rst_sync_b (rst_sync_ff),
    .sel        (nxt_aug_lead[AMP_A_SEL_LSB +: SEL_W]),
    .onehot     (central_amp_a_input_sel)
  );

  ct_input_decoder u_dec_b (
    .core_clk   (core_clk),
    .rst_sync_b (rst_sync_ff),
    .sel        (nxt_amp_bc[AMP_B_SEL_LSB +: SEL_W]),
    .onehot     (central_amp_b_input_sel)
  );

  ct_input_decoder u_dec_c (
    .core_clk   (core_clk),
    .rst_sync_b (rst_sync_ff),
    .sel        (nxt_amp_bc[AMP_C_SEL_LSB +: SEL_W]),
    .onehot     (central_amp_c_input_sel)
  );

  // Register write, output line and ready handshake checks
  chk_aug_write: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    complete && pwrite && paddr == AUG_LEAD_ADDR |=> aug_lead_ff == $past(pwdata[7:0]))
    else $error("augmented register write lost");
  chk_bc_write: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    complete && pwrite && paddr == AMP_BC_ADDR |=> amp_bc_ff == $past(pwdata[7:0]))
    else $error("amp b/c register write lost");
  chk_ch6_path: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    foot_lead_to_ch6_en == aug_lead_ff[FOOT_CH6_BIT]) else $error("ch6 path wrong");
  chk_ch5_path: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    left_lead_to_ch5_en == aug_lead_ff[LEFT_CH5_BIT]) else $error("ch5 path wrong");
  chk_ch7_path: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    right_lead_to_ch7_en == aug_lead_ff[RIGHT_CH7_BIT]) else $error("ch7 path wrong");
  chk_ch4_path: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    right_lead_to_ch4_en == aug_lead_ff[RIGHT_CH4_BIT]) else $error("ch4 path wrong");
  chk_amp_power: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    complete && pwrite && paddr == AUG_LEAD_ADDR |=>
    central_amp_a_power_on == $past(pwdata[AMP_A_PWR_BIT])) else $error("A power wrong");
  chk_bc_power: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    central_amp_c_power_on == amp_bc_ff[AMP_C_PWR_BIT]
    && central_amp_b_power_on == amp_bc_ff[AMP_B_PWR_BIT]) else $error("B/C power wrong");
  chk_sel_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    central_amp_a_input_sel[aug_lead_ff[AMP_A_SEL_LSB +: SEL_W]]) else $error("A sel wrong");
  chk_sel_b: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    central_amp_b_input_sel[amp_bc_ff[AMP_B_SEL_LSB +: SEL_W]]) else $error("B sel wrong");
  chk_sel_c: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    central_amp_c_input_sel[amp_bc_ff[AMP_C_SEL_LSB +: SEL_W]]) else $error("C sel wrong");
  chk_ready_pulse: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    psel && penable && !pready |=> pready) else $error("no answer");


  // Read data carries the stored byte of register 0
  chk_read_aug: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    access && !pwrite && paddr == AUG_LEAD_ADDR |=>
    prdata == {24'h000000, $past(aug_lead_ff)})
    else $error("augmented register read wrong");

  // Read data carries the stored byte of register 1
  chk_read_bc: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    access && !pwrite && paddr == AMP_BC_ADDR |=>
    prdata == {24'h000000, $past(amp_bc_ff)})
    else $error("amp b/c register read wrong");

  // Unmapped word is answered with an error
  chk_bad_addr_err: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    access && !addr_hit(paddr) |=>
    pready && pslverr)
    else $error("unmapped access not refused");

  // Mapped word is answered without error
  chk_good_addr_ok: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    access && addr_hit(paddr) |=>
    pready && !pslverr)
    else $error("mapped access refused");

  // Refused write leaves both registers alone
  chk_bad_write_kept: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    complete && pwrite && !addr_hit(paddr) |=>
    $stable(aug_lead_ff) && $stable(amp_bc_ff))
    else $error("unmapped write changed a register");

  // Without a completed write the registers hold
  chk_idle_kept: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    !(complete && pwrite) |=>
    $stable(aug_lead_ff) && $stable(amp_bc_ff))
    else $error("register changed without write");

  // Ready is a single-cycle pulse
  chk_ready_single: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    pready |=>
    !pready)
    else $error("ready held too long");

  // Error only shows together with ready
  chk_err_ready: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    pslverr |->
    pready)
    else $error("error without ready");

  // Amplifier B power follows the written bit
  chk_b_power: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    complete && pwrite && paddr == AMP_BC_ADDR |=>
    central_amp_b_power_on == $past(pwdata[AMP_B_PWR_BIT]))
    else $error("B power wrong");

  // Amplifier C power follows the written bit
  chk_c_power: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    complete && pwrite && paddr == AMP_BC_ADDR |=>
    central_amp_c_power_on == $past(pwdata[AMP_C_PWR_BIT]))
    else $error("C power wrong");

  // Amplifier A switch line follows the written code in the same edge
  chk_sel_a_write: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    complete && pwrite && paddr == AUG_LEAD_ADDR |=>
    central_amp_a_input_sel[$past(pwdata[AMP_A_SEL_LSB +: SEL_W])])
    else $error("A sel late");

  // Amplifier C switch line follows the written code in the same edge
  chk_sel_c_write: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    complete && pwrite && paddr == AMP_BC_ADDR |=>
    central_amp_c_input_sel[$past(pwdata[AMP_C_SEL_LSB +: SEL_W])])
    else $error("C sel late");

  // Upper read bits always zero
  chk_rdata_upper: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    prdata[31:8] == 24'h000000)
    else $error("upper read bits set");

  // Main scenarios seen
  cov_aug_write: cover property (@(posedge core_clk) complete && pwrite && paddr == AUG_LEAD_ADDR);
  cov_bad_write: cover property (@(posedge core_clk)
    complete && pwrite && !addr_hit(paddr));
  cov_reset_release: cover property (@(posedge core_clk)
    $rose(rst_sync_ff));
  cov_bc_read: cover property (@(posedge core_clk) access && !pwrite && paddr == AMP_BC_ADDR);
  cov_bad_addr: cover property (@(posedge core_clk) pready && pslverr);

endmodule

// file: central_terminal_switch_config_bench.sv
`timescale 1ns/1ps
module central_terminal_switch_config_bench;
  import ct_switch_pkg::*;
  typedef struct packed {
    logic [7:0] r0;
    logic [7:0] r1;
    logic [6:0] fl;
    logic [7:0] sab;
    logic [7:0] sc;
  } row_t;
  logic                  core_clk = 1'b0;
  logic                  rst_b    = 1'b0;
  logic                  psel     = 1'b0;
  logic                  penable  = 1'b0;
  logic                  pwrite   = 1'b0;
  logic [ADDR_W-1:0]     paddr    = '0;
  logic [31:0]           pwdata   = 32'h0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [6:0]            flags;
  logic [NUM_INPUTS-1:0] sel_a;
  logic [NUM_INPUTS-1:0] sel_b;
  logic [NUM_INPUTS-1:0] sel_c;
  logic [31:0]           rd;
  logic                  err;
  row_t                  row;
  int                    error_cnt = 0;
  int                    cmp_count = 0;
  // Code n in each select field; C runs backwards so a B/C swap shows
  logic [38:0] rows [8] = '{
    {8'h80, 8'h07, 7'h40, 8'h01, 8'h80}, {8'h41, 8'h0e, 7'h20, 8'h02, 8'h40},
    {8'h22, 8'h15, 7'h10, 8'h04, 8'h20}, {8'h13, 8'h1c, 7'h08, 8'h08, 8'h10},
    {8'h0c, 8'h23, 7'h04, 8'h10, 8'h08}, {8'h05, 8'h6a, 7'h02, 8'h20, 8'h04},
    {8'h06, 8'hb1, 7'h01, 8'h40, 8'h02}, {8'hff, 8'hf8, 7'h7f, 8'h80, 8'h01}};

  // Clock at 40 MHz
  always #12.5 core_clk = ~core_clk;

  ct_switch_cfg dut (
    .core_clk               (core_clk),
    .rst_b                  (rst_b),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .foot_lead_to_ch6_en    (flags[6]),
    .left_lead_to_ch5_en    (flags[5]),
    .right_lead_to_ch7_en   (flags[4]),
    .right_lead_to_ch4_en   (flags[3]),
    .central_amp_a_power_on (flags[2]),
    .central_amp_b_power_on (flags[1]),
    .central_amp_c_power_on (flags[0]),
    .central_amp_a_input_sel(sel_a),
    .central_amp_b_input_sel(sel_b),
    .central_amp_c_input_sel(sel_c)
  );

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Compares every register-driven output with the expected levels
  task automatic cmp_outs(input logic [6:0] f, input logic [7:0] a, input logic [7:0] b,
                          input logic [7:0] c);
    #1;
    cmp({25'h0, flags}, {25'h0, f});
    cmp({sel_a, sel_b, sel_c}, {a, b, c});
  endtask

  task automatic close_out;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    #(4000 * 25);
    error_cnt++;
    close_out;
  end

  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    cmp_outs(7'h00, 8'h01, 8'h01, 8'h01);
    apb(1'b0, AUG_LEAD_ADDR, 32'h0);
    cmp(rd, {24'h0, AUG_LEAD_RST});
    apb(1'b0, AMP_BC_ADDR, 32'h0);
    cmp(rd, {24'h0, AMP_BC_RST});
    // Table of field settings, upper write bits set to show they are dropped
    for (int i = 0; i < 8; i++)
    begin
      row = rows[i];
      apb(1'b1, AUG_LEAD_ADDR, {24'ha5a5a5, row.r0});
      apb(1'b1, AMP_BC_ADDR, {24'h5a5a5a, row.r1});
      cmp({31'h0, err}, 32'h0);
      cmp_outs(row.fl, row.sab, row.sab, row.sc);
      apb(1'b0, AUG_LEAD_ADDR, 32'h0);
      cmp(rd, {24'h0, row.r0});
      apb(1'b0, AMP_BC_ADDR, 32'h0);
      cmp(rd, {24'h0, row.r1});
    end
    // Unmapped word: refused, nothing stored, reads zero
    apb(1'b1, AMP_BC_ADDR + 12'h004, 32'h0000_0000);
    cmp({31'h0, err}, 32'h1);
    apb(1'b0, AMP_BC_ADDR + 12'h004, 32'h0);
    cmp({31'h0, err}, 32'h1);
    cmp(rd, 32'h0);
    cmp_outs(7'h7f, 8'h80, 8'h80, 8'h01);
    // Clearing bits 7 and 3 leaves the other fields untouched
    apb(1'b1, AUG_LEAD_ADDR, 32'h0000_0077);
    cmp_outs(7'h3b, 8'h80, 8'h80, 8'h01);
    // Reset in mid-run returns registers and flags to zero, select lines to code 0
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    cmp_outs(7'h00, 8'h01, 8'h01, 8'h01);
    @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(1'b0, AUG_LEAD_ADDR, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b0, AMP_BC_ADDR, 32'h0);
    cmp(rd, 32'h0);
    close_out;
  end
endmodule
